// ---- src/ecc_dev.sv ----
// memory control device: nonvolatile array, shadow array, live registers
//
// Our own choice: the register link port.
`timescale 1ns/1ps
`include "ecc_consts.svh"
module ecc_dev #(
  parameter int unsigned CYCLE_CLKS = 32'(`ECC_CYCLE_CLKS)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register link
  ecc_link_if.dev  link
);
  import ecc_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  ecc_byte_type  nvm_mem [`ECC_NVM_NUM];
  ecc_byte_type  shadow_mem [`ECC_LIVE_NUM];
  ecc_byte_type  live_r [`ECC_LIVE_NUM];
  ecc_state_type state_r;
  logic [3:0]    idx_r;
  logic [31:0]   timer_r;
  ecc_byte_type  crc_r;
  ecc_byte_type  scheck_r;
  ecc_byte_type  pcount_r;
  ecc_byte_type  unlock_r;
  logic          mismatch_r;
  logic          autochk_r;
  logic          unl_ok_r;
  logic          also_prog_r;
  logic          ack_r;
  ecc_byte_type  rdata_r;
  logic          take;
  logic          wr;
  logic          ctl_wr;
  logic          busy;

  function automatic ecc_byte_type crc8(input ecc_byte_type acc, input ecc_byte_type d);
    ecc_byte_type c;
    c = acc ^ d;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ((c << 1) ^ `ECC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  // factory contents: the array is nonvolatile, so reset does not touch it
  initial begin
    for (int i = 0; i < `ECC_CFG_NUM; i++) begin
      nvm_mem[i] = 8'(i);
    end
    nvm_mem[`ECC_LIVE_CHK_IDX] = 8'h00;
    for (int i = 0; i < `ECC_CFG_NUM; i++) begin
      nvm_mem[`ECC_LIVE_CHK_IDX] = crc8(nvm_mem[`ECC_LIVE_CHK_IDX], nvm_mem[i]);
    end
    nvm_mem[`ECC_NVM_CNT_IDX] = `ECC_PCOUNT_RST;
  end

  // ----------------------------------------------------------------------
  // link decode
  // ----------------------------------------------------------------------
  // reads are held off while a load runs, writes are always answered
  assign take   = link.req && !ack_r && (link.we || state_r != ECC_LOAD);
  assign wr     = take && link.we;
  assign busy   = (state_r == ECC_ERASE) || (state_r == ECC_PROG) ||
                  (state_r == ECC_COUNT) || (state_r == ECC_RECNT);
  // control commands are only taken when nothing else is running
  assign ctl_wr = wr && (link.addr == `ECC_A_NVCTL) && (state_r == ECC_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 8'h00;
    end else if (take && !link.we) begin
      if (link.addr < `ECC_LIVE_NUM) begin
        rdata_r <= live_r[link.addr[3:0]];
      end else begin
        unique case (link.addr)
          `ECC_A_SCHECK: rdata_r <= scheck_r;
          `ECC_A_PCOUNT: rdata_r <= pcount_r;
          `ECC_A_UNLOCK: rdata_r <= unlock_r;
          `ECC_A_NVCTL:  rdata_r <= {1'b0, state_r == ECC_COPY, mismatch_r, autochk_r,
                                     1'b0, busy, 2'b00};
          default:       rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // unlock tracking: only the transaction right before counts
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_ok_r <= 1'b0;
      unlock_r <= 8'h00;
    end else if (take) begin
      unl_ok_r <= wr && (link.addr == `ECC_A_UNLOCK) && (link.wdata == `ECC_UNLOCK_KEY);
      if (wr && link.addr == `ECC_A_UNLOCK) begin
        unlock_r <= link.wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autochk_r <= `ECC_AUTOCHK_RST;
    end else if (ctl_wr) begin
      autochk_r <= link.wdata[`ECC_B_AUTOCHK];
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ECC_LOAD;
      idx_r       <= 4'h0;
      timer_r     <= 32'h0;
      also_prog_r <= 1'b0;
    end else begin
      unique case (state_r)
        ECC_LOAD: begin
          idx_r   <= idx_r + 4'h1;
          state_r <= (idx_r == 4'(`ECC_LIVE_NUM)) ? ECC_IDLE : ECC_LOAD;
        end
        ECC_IDLE: begin
          idx_r   <= 4'h0;
          timer_r <= 32'h0;
          if (ctl_wr && link.wdata[`ECC_B_LOAD]) begin
            state_r <= ECC_LOAD;
          end else if (ctl_wr && link.wdata[`ECC_B_REGCOPY]) begin
            state_r <= ECC_COPY;
          end else if (ctl_wr && unl_ok_r && link.wdata[`ECC_B_ERASE]) begin
            state_r     <= ECC_ERASE;
            also_prog_r <= link.wdata[`ECC_B_PROG];
          end else if (ctl_wr && unl_ok_r && link.wdata[`ECC_B_PROG]) begin
            state_r <= ECC_PROG;
          end
          // a start without the key simply falls away here
        end
        ECC_COPY: begin
          idx_r   <= idx_r + 4'h1;
          state_r <= (idx_r == 4'(`ECC_LIVE_NUM - 1)) ? ECC_IDLE : ECC_COPY;
        end
        ECC_ERASE: begin
          timer_r <= timer_r + 32'h1;
          if (timer_r == CYCLE_CLKS - 1) begin
            timer_r     <= 32'h0;
            also_prog_r <= 1'b0;
            state_r     <= also_prog_r ? ECC_PROG : ECC_COUNT;
          end
        end
        ECC_PROG: begin
          timer_r <= timer_r + 32'h1;
          if (timer_r == CYCLE_CLKS - 1) begin
            state_r <= ECC_COUNT;
          end
        end
        ECC_COUNT: state_r <= ECC_RECNT;
        ECC_RECNT: state_r <= ECC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // nonvolatile array writes
  // ----------------------------------------------------------------------
  // plain always: the factory image is written by an initial block as well
  always @(posedge pclk) begin
    if (state_r == ECC_ERASE && timer_r == CYCLE_CLKS - 1) begin
      for (int i = 0; i < `ECC_LIVE_NUM; i++) begin
        nvm_mem[i] <= `ECC_ERASED;
      end
    end
    if (state_r == ECC_PROG && timer_r == CYCLE_CLKS - 1) begin
      for (int i = 0; i < `ECC_CFG_NUM; i++) begin
        nvm_mem[i] <= shadow_mem[i];
      end
      nvm_mem[`ECC_LIVE_CHK_IDX] <= autochk_r ? crc_r : shadow_mem[`ECC_LIVE_CHK_IDX];
    end
    if (state_r == ECC_COUNT && nvm_mem[`ECC_NVM_CNT_IDX] != `ECC_PCOUNT_MAX) begin
      nvm_mem[`ECC_NVM_CNT_IDX] <= nvm_mem[`ECC_NVM_CNT_IDX] + 8'h01;
    end
  end

  // shadow array is filled by the register commit, one byte a cycle
  always_ff @(posedge pclk) begin
    if (state_r == ECC_COPY) begin
      shadow_mem[idx_r] <= live_r[idx_r];
    end
  end

  // check over the shadow bytes, worked out while the program timer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r <= 8'h00;
    end else if (state_r == ECC_LOAD && idx_r < 4'(`ECC_CFG_NUM)) begin
      crc_r <= crc8(idx_r == 4'h0 ? 8'h00 : crc_r, nvm_mem[idx_r]);
    end else if (state_r == ECC_PROG && timer_r < `ECC_CFG_NUM) begin
      crc_r <= crc8(timer_r == 32'h0 ? 8'h00 : crc_r, shadow_mem[timer_r[3:0]]);
    end
  end

  // ----------------------------------------------------------------------
  // live registers and read-only status
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ECC_LIVE_NUM; i++) begin
        live_r[i] <= 8'h00;
      end
    end else if (state_r == ECC_LOAD && idx_r < 4'(`ECC_LIVE_NUM)) begin
      live_r[idx_r] <= nvm_mem[idx_r];
    end else if (wr && state_r == ECC_IDLE && link.addr < `ECC_LIVE_NUM) begin
      live_r[link.addr[3:0]] <= link.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scheck_r   <= 8'h00;
      mismatch_r <= 1'b0;
    end else if (state_r == ECC_LOAD && idx_r == 4'(`ECC_LIVE_NUM)) begin
      scheck_r   <= nvm_mem[`ECC_LIVE_CHK_IDX];
      mismatch_r <= crc_r != nvm_mem[`ECC_LIVE_CHK_IDX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcount_r <= `ECC_PCOUNT_RST;
    end else if ((state_r == ECC_LOAD && idx_r == 4'(`ECC_LIVE_NUM)) ||
                 state_r == ECC_RECNT) begin
      pcount_r <= nvm_mem[`ECC_NVM_CNT_IDX];
    end
  end

  assign link.ack   = ack_r;
  assign link.rdata = rdata_r;
endmodule : ecc_dev

// ---- src/ecc_consts.svh ----
// constants shared by both ends of the nonvolatile-memory control link
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH

// ----------------------------------------------------------------------
// device register map (link addresses)
// ----------------------------------------------------------------------
`define ECC_LIVE_BASE     8'h00
`define ECC_LIVE_NUM      9
`define ECC_LIVE_CHK_IDX  8
`define ECC_CFG_NUM       8
`define ECC_NVM_NUM       10
`define ECC_NVM_CNT_IDX   9
`define ECC_A_SCHECK      8'h2F
`define ECC_A_PCOUNT      8'h30
`define ECC_A_NVCTL       8'h31
`define ECC_A_UNLOCK      8'h38
`define ECC_UNLOCK_KEY    8'hBE

// ----------------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------------
`define ECC_B_REGCOPY     6
`define ECC_B_MISMATCH    5
`define ECC_B_AUTOCHK     4
`define ECC_B_LOAD        3
`define ECC_B_BUSY        2
`define ECC_B_ERASE       1
`define ECC_B_PROG        0
`define ECC_AUTOCHK_RST   1'b1
`define ECC_PCOUNT_RST    8'h01
`define ECC_PCOUNT_MAX    8'hFF
`define ECC_ERASED        8'hFF
`define ECC_CRC_POLY      8'h07

// ----------------------------------------------------------------------
// timing: 250 MHz clock, 4 ns period
// ----------------------------------------------------------------------
`define ECC_CLK_PS        4000
`define ECC_CYCLE_MS      115
`define ECC_CYCLE_CLKS    ((`ECC_CYCLE_MS * 64'd1000000000) / `ECC_CLK_PS)

// ----------------------------------------------------------------------
// host controller APB map
// ----------------------------------------------------------------------
`define ECC_H_CMD         8'h00
`define ECC_H_STAT        8'h04
`define ECC_H_ISTAT       8'h08
`define ECC_H_IMASK       8'h0C
`define ECC_CMD_WE        16
`define ECC_CMD_UNLK      17
`define ECC_I_DONE        0
`define ECC_I_REFUSED     1

`endif

// ---- src/ecc_pkg.sv ----
// types shared by both ends of the nonvolatile-memory control link
package ecc_pkg;
  typedef logic [7:0] ecc_byte_type;
  typedef enum logic [2:0] {
    ECC_LOAD, ECC_IDLE, ECC_COPY, ECC_ERASE, ECC_PROG, ECC_COUNT, ECC_RECNT
  } ecc_state_type;
endpackage : ecc_pkg

// ---- src/ecc_link_if.sv ----
// register link between the host controller and the memory control device
`timescale 1ns/1ps
interface ecc_link_if;
  import ecc_pkg::*;
  logic         req;
  logic         we;
  ecc_byte_type addr;
  ecc_byte_type wdata;
  logic         ack;
  ecc_byte_type rdata;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface : ecc_link_if

// ---- src/ecc_host.sv ----
// host controller: APB registers turned into single link transactions
`timescale 1ns/1ps
`include "ecc_consts.svh"
module ecc_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // register link
  ecc_link_if.host         link
);
  import ecc_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic         req_r;
  logic         we_r;
  ecc_byte_type addr_r;
  ecc_byte_type wdata_r;
  ecc_byte_type pwdata_hold_r;
  logic         pend_r;
  logic         busy_seen_r;
  ecc_byte_type last_rd_r;
  logic [1:0]   istat_r;
  logic [1:0]   imask_r;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         irq_r;
  logic         apb_wr;
  logic         cmd_wr;
  logic         refuse;
  logic         done_ev;
  logic [1:0]   set_v;

  assign apb_wr  = psel && penable && pready_r && pwrite;
  assign cmd_wr  = apb_wr && paddr == `ECC_H_CMD && !req_r;
  // a start of erase/program is not sent while the device last showed busy
  assign refuse  = cmd_wr && pwdata[`ECC_CMD_WE] && pwdata[7:0] == `ECC_A_NVCTL &&
                   busy_seen_r && (pwdata[8 + `ECC_B_ERASE] || pwdata[8 + `ECC_B_PROG]);
  assign done_ev = req_r && link.ack && !pend_r;
  assign set_v   = {refuse, done_ev};

  // ----------------------------------------------------------------------
  // APB slave: data set up in the setup phase, one access cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        unique case (paddr)
          `ECC_H_CMD:   prdata_r <= {15'h0, we_r, wdata_r, addr_r};
          `ECC_H_STAT:  prdata_r <= {16'h0, last_rd_r, 6'h0, busy_seen_r, req_r};
          `ECC_H_ISTAT: prdata_r <= {30'h0, istat_r};
          `ECC_H_IMASK: prdata_r <= {30'h0, imask_r};
          default:      prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // link transactions: one at a time, held until answered
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      pend_r  <= 1'b0;
    end else if (cmd_wr && !refuse) begin
      req_r <= 1'b1;
      if (pwdata[`ECC_CMD_UNLK]) begin
        // key goes first; the real write follows with no gap between
        we_r    <= 1'b1;
        addr_r  <= `ECC_A_UNLOCK;
        wdata_r <= `ECC_UNLOCK_KEY;
        pend_r  <= 1'b1;
      end else begin
        we_r    <= pwdata[`ECC_CMD_WE];
        addr_r  <= pwdata[7:0];
        wdata_r <= pwdata[15:8];
      end
    end else if (req_r && link.ack) begin
      if (pend_r) begin
        pend_r  <= 1'b0;
        we_r    <= 1'b1;
        addr_r  <= `ECC_A_NVCTL;
        wdata_r <= pwdata_hold_r;
      end else begin
        req_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwdata_hold_r <= 8'h00;
    end else if (cmd_wr && pwdata[`ECC_CMD_UNLK]) begin
      pwdata_hold_r <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rd_r   <= 8'h00;
      busy_seen_r <= 1'b0;
    end else if (done_ev && !we_r) begin
      last_rd_r <= link.rdata;
      if (addr_r == `ECC_A_NVCTL) begin
        busy_seen_r <= link.rdata[`ECC_B_BUSY];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupts: set wins over a write-one clear
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 2'b00;
      imask_r <= 2'b00;
      irq_r   <= 1'b0;
    end else begin
      if (apb_wr && paddr == `ECC_H_ISTAT) begin
        istat_r <= (istat_r & ~pwdata[1:0]) | set_v;
      end else begin
        istat_r <= istat_r | set_v;
      end
      if (apb_wr && paddr == `ECC_H_IMASK) begin
        imask_r <= pwdata[1:0];
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = 1'b0;
  assign irq        = irq_r;
  assign link.req   = req_r;
  assign link.we    = we_r;
  assign link.addr  = addr_r;
  assign link.wdata = wdata_r;
endmodule : ecc_host

// ---- tb/ecc_link_asserts.sv ----
// checker on the register link between the host controller and the device
`timescale 1ns/1ps
`include "ecc_consts.svh"
module ecc_link_asserts #(
  parameter int unsigned CYCLE_CLKS = 32'(`ECC_CYCLE_CLKS)
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // link signals
  input wire logic                  req,
  input wire logic                  we,
  input wire ecc_pkg::ecc_byte_type addr,
  input wire ecc_pkg::ecc_byte_type wdata,
  input wire logic                  ack,
  input wire ecc_pkg::ecc_byte_type rdata
);
  import ecc_pkg::*;
  logic         rd31, rd30, rd2f, wr31, kst, idle;
  logic         armed_r, ctl_wr_r, nokey_r, chk_ok_r;
  logic [3:0]   rst_cnt_r, copy_cnt_r;
  logic [31:0]  run_cnt_r, len_r;
  ecc_byte_type cnt_r, chk_r;

  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  // the host holds the fields while ack is high, so ack marks a finished transaction
  assign rd31 = ack && !we && addr == `ECC_A_NVCTL;
  assign rd30 = ack && !we && addr == `ECC_A_PCOUNT;
  assign rd2f = ack && !we && addr == `ECC_A_SCHECK;
  assign wr31 = ack && we && addr == `ECC_A_NVCTL;
  assign idle = run_cnt_r > len_r + 32'd6;
  assign kst  = wr31 && wdata[1:0] != 2'h0 && armed_r && !wdata[3] && !wdata[6];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r    <= 1'b0;
      ctl_wr_r   <= 1'b0;
      nokey_r    <= 1'b0;
      rst_cnt_r  <= 4'h0;
      copy_cnt_r <= 4'hF;
    end else begin
      if (ack) armed_r <= we && addr == `ECC_A_UNLOCK && wdata == `ECC_UNLOCK_KEY;
      if (wr31) ctl_wr_r <= 1'b1;
      if (kst) nokey_r <= 1'b0;
      else if (wr31 && wdata[1:0] != 2'h0 && !armed_r && idle) nokey_r <= 1'b1;
      if (rst_cnt_r != 4'hF) rst_cnt_r <= rst_cnt_r + 4'h1;
      if (wr31 && wdata[6]) copy_cnt_r <= 4'h0;
      else if (copy_cnt_r != 4'hF) copy_cnt_r <= copy_cnt_r + 4'h1;
    end
  end
  // a combined erase and program runs twice as long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_r <= 32'hFFFF;
      len_r     <= 32'h0;
    end else if (kst) begin
      run_cnt_r <= 32'h0;
      len_r     <= (wdata[1:0] == 2'h3) ? 2 * CYCLE_CLKS : CYCLE_CLKS;
    end else if (run_cnt_r < 32'hFFFF) begin
      run_cnt_r <= run_cnt_r + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 8'h00;
      chk_r    <= 8'h00;
      chk_ok_r <= 1'b0;
    end else begin
      if (rd30) cnt_r <= rdata;
      if (wr31) chk_ok_r <= 1'b0;
      else if (rd2f) chk_ok_r <= 1'b1;
      if (rd2f) chk_r <= rdata;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_no_read_load: assert property (ack && !we |-> rst_cnt_r >= 4'hA)
    else $error("read answered during the reset load");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_bounded: assert property (req && !ack |-> ##[1:64] ack)
    else $error("request not answered");
  a_busy_held: assert property (rd31 && run_cnt_r < len_r |-> rdata[`ECC_B_BUSY])
    else $error("busy low during a cycle");
  a_busy_ends: assert property (rd31 && idle |-> !rdata[`ECC_B_BUSY])
    else $error("busy high outside a cycle");
  a_refused_idle: assert property (rd31 && nokey_r |-> !rdata[`ECC_B_BUSY])
    else $error("cycle started without the key");
  a_start_clear: assert property (rd31 |-> rdata[1:0] == 2'h0)
    else $error("start bits read back set");
  a_load_clear: assert property (rd31 |-> !rdata[`ECC_B_LOAD])
    else $error("load bit read back set");
  a_auto_reset: assert property (rd31 && !ctl_wr_r |-> rdata[`ECC_B_AUTOCHK])
    else $error("auto check bit not set after reset");
  a_copy_clears: assert property (rd31 && copy_cnt_r == 4'hF |-> !rdata[`ECC_B_REGCOPY])
    else $error("copy bit stuck");
  a_count_mono: assert property (rd30 |-> rdata >= cnt_r)
    else $error("program count went down");
  a_check_ro: assert property (rd2f && chk_ok_r |-> rdata == chk_r)
    else $error("stored check byte changed");
  c_keyed: cover property (kst);
  c_busy: cover property (rd31 && rdata[`ECC_B_BUSY]);
  c_copy: cover property (rd31 && rdata[`ECC_B_REGCOPY]);
  c_max: cover property (rd30 && rdata == 8'hFF);
endmodule : ecc_link_asserts

// ---- tb/testbench.sv ----
// testbench: APB drives the host controller joined to the memory control device
`timescale 1ns/1ps
`include "ecc_consts.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, (e), (s)); end end
module testbench;
  import ecc_pkg::*;
  localparam int unsigned CYC = 20;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, q;
  int           n_fail, comparisons;
  ecc_byte_type live [8];
  ecc_byte_type cnt, r, man;

  ecc_link_if link ();
  ecc_dev #(.CYCLE_CLKS(CYC)) ecc_dev_inst (.pclk(pclk), .presetn(presetn), .link(link));
  ecc_host ecc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  ecc_link_asserts #(.CYCLE_CLKS(CYC)) ecc_link_asserts_inst (.pclk(pclk),
    .presetn(presetn), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  // ----------------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------------
  function automatic ecc_byte_type crc8(input ecc_byte_type b [8]);
    ecc_byte_type c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c = c ^ b[i];
      for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ `ECC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8
  function automatic ecc_byte_type sat(input ecc_byte_type c);
    return (c == `ECC_PCOUNT_MAX) ? c : c + 8'h01;
  endfunction : sat
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one link transaction; c holds {key first, write, data, address}
  task automatic op(input logic [17:0] c);
    apb(1'b1, `ECC_H_CMD, {14'h0, c});
    do apb(1'b0, `ECC_H_STAT, 32'h0); while (q[0] !== 1'b0);
    r = q[15:8];
  endtask : op
  task automatic rd(input ecc_byte_type a);
    op({2'h0, 8'h00, a});
  endtask : rd
  task automatic wr(input ecc_byte_type a, input ecc_byte_type d);
    op({2'h1, d, a});
  endtask : wr
  task automatic start(input ecc_byte_type d);
    op({2'h3, d, `ECC_A_NVCTL});
    do rd(`ECC_A_NVCTL); while (r[`ECC_B_BUSY] !== 1'b0);
    cnt = sat(cnt);
  endtask : start
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32));
    cnt = `ECC_PCOUNT_RST;
    for (int i = 0; i < 8; i++) live[i] = ecc_byte_type'(i);
    rd(`ECC_A_PCOUNT);
    `CHK("count", cnt, r)
    rd(`ECC_A_NVCTL);
    `CHK("control", 8'h10, r)
    rd(`ECC_A_SCHECK);
    wr(`ECC_A_SCHECK, 8'h5A);
    rd(`ECC_A_SCHECK);
    `CHK("check byte", crc8(live), r)
    rd(8'h20);
    `CHK("unmapped", 8'h00, r)
    // random settings pass through commit, program and load
    for (int i = 0; i < 8; i++) begin
      live[i] = ecc_byte_type'($urandom);
      wr(ecc_byte_type'(i), live[i]);
    end
    wr(`ECC_A_NVCTL, 8'h50);
    do rd(`ECC_A_NVCTL); while (r[`ECC_B_REGCOPY] !== 1'b0);
    start(8'h11);
    wr(`ECC_A_NVCTL, 8'h18);
    rd(`ECC_A_SCHECK);
    `CHK("check byte", crc8(live), r)
    rd(`ECC_A_PCOUNT);
    `CHK("count", cnt, r)
    for (int i = 0; i < 8; i++) begin
      rd(ecc_byte_type'(i));
      `CHK("live", live[i], r)
    end
    // start without the key, and with a read between key and start
    wr(`ECC_A_NVCTL, 8'h11);
    rd(`ECC_A_NVCTL);
    `CHK("busy", 1'b0, r[`ECC_B_BUSY])
    wr(`ECC_A_UNLOCK, `ECC_UNLOCK_KEY);
    rd(`ECC_A_PCOUNT);
    wr(`ECC_A_NVCTL, 8'h12);
    rd(`ECC_A_NVCTL);
    `CHK("busy", 1'b0, r[`ECC_B_BUSY])
    rd(`ECC_A_PCOUNT);
    `CHK("count", cnt, r)
    // erase alone leaves an all-ones image whose check byte disagrees
    start(8'h12);
    wr(`ECC_A_NVCTL, 8'h18);
    for (int i = 0; i < 8; i++) live[i] = `ECC_ERASED;
    rd(`ECC_A_NVCTL);
    `CHK("mismatch", crc8(live) != `ECC_ERASED, r[`ECC_B_MISMATCH])
    rd(8'h00);
    `CHK("erased", `ECC_ERASED, r)
    start(8'h13);
    rd(`ECC_A_PCOUNT);
    `CHK("count", cnt, r)
    // host refuses a start while busy; interrupt raised, masked, cleared
    op({2'h3, 8'h11, `ECC_A_NVCTL});
    rd(`ECC_A_NVCTL);
    wr(`ECC_A_NVCTL, 8'h11);
    apb(1'b0, `ECC_H_ISTAT, 32'h0);
    `CHK("refused", 1'b1, q[`ECC_I_REFUSED])
    `CHK("slave error", 1'b0, pslverr)
    apb(1'b1, `ECC_H_IMASK, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, `ECC_H_ISTAT, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `ECC_H_IMASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, `ECC_H_IMASK, 32'h0);
    do rd(`ECC_A_NVCTL); while (r[`ECC_B_BUSY] !== 1'b0);
    cnt = sat(cnt);
    // auto-check off: the stored byte comes from live register 8
    man = ecc_byte_type'($urandom);
    wr(8'h08, man);
    wr(`ECC_A_NVCTL, 8'h40);
    do rd(`ECC_A_NVCTL); while (r[`ECC_B_REGCOPY] !== 1'b0);
    `CHK("auto check", 1'b0, r[`ECC_B_AUTOCHK])
    start(8'h01);
    wr(`ECC_A_NVCTL, 8'h08);
    rd(`ECC_A_SCHECK);
    `CHK("manual check", man, r)
    // run the count up to its ceiling and once past it
    while (cnt != `ECC_PCOUNT_MAX) begin
      start(8'h11);
      rd(`ECC_A_PCOUNT);
      `CHK("count", cnt, r)
    end
    start(8'h11);
    rd(`ECC_A_PCOUNT);
    `CHK("count", `ECC_PCOUNT_MAX, r)
    // the stored count comes back after a second reset
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ECC_A_PCOUNT);
    `CHK("count", `ECC_PCOUNT_MAX, r)
    stop_test();
  end
endmodule : testbench
